// ===== logic/msv_pkg.sv
// Purpose: Shared constants and types for the memory rail supervisor.
// Assumes: 250 MHz system clock; switching timebase derived by a divider.
// Notes: Register map sits on APB with 32-bit words.
// Operation
// - Soft-start entry sets reference to reduced starting code and halves overcurrent threshold.
// - Above 80 percent, step the 4-bit reference code to full over 85 us.
// - At ramp end restore the overcurrent threshold to nominal.
// - Release power-good only after full reference, rail above 95 percent, then 45 us.
// - Termination limit reduced while termination good is false, normal when good.
// - Termination good sets inside 5 percent, clears outside 10 percent.
// - Separate soft-start counters per rail; power-good shows main rail only.
// - Discharge outputs when both sleep controls go low from any non-off state, per discharge mode.
// - Decode three-way discharge mode: bias none, main tracking, ground non-tracking.
// - Tracking discharge via termination regulator until main below 0.2 V, then non-tracking.
// - Non-tracking discharge turns on main sense and termination switches.
// - No-discharge mode leaves every discharge path off.
// - Keep high-side off during off interval while current exceeds trip level.
// - Resistor sensing selects the fixed 60 mV trip level.
// - Main rail below power-good level in operation halves the trip level.
// - Feedback above 115 percent latches high-side off, low-side on.
// - Main sense above 4 V forces the high-side driver off.
// - Feedback below 70 percent for 32 cycles latches both drivers off.
// - Undervoltage protection disabled until 1007 switching cycles after start.
// - Bias lockout shuts all regulators and reference off, resumes without latching.
// - Rail select tied to bias or ground selects internal feedback divider.
// - Suspend low, soft-off high keeps main and reference on, termination high impedance.
package msv_pkg;
  localparam int CLK_MHZ = 250;
  localparam int SW_FREQ_KHZ = 400;
  localparam int TICK_CYC = CLK_MHZ * 1000 / SW_FREQ_KHZ;
  localparam int RAMP_US = 85;
  localparam int RAMP_CYC = RAMP_US * CLK_MHZ;
  localparam int PG_DELAY_US = 45;
  localparam int PG_DELAY_CYC = PG_DELAY_US * CLK_MHZ;
  localparam int UV_DELAY_SW = 32;
  localparam int UV_ARM_SW = 1007;
  localparam logic [3:0] DAC_START = 4'h0;
  localparam logic [3:0] DAC_FULL = 4'hF;
  localparam int DAC_STEPS = 15;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_COUNT = 8'h08;
  localparam logic [1:0] CTRL_RESET = 2'h3;
  localparam int CTRL_UVP_BIT = 0;
  localparam int CTRL_OVP_BIT = 1;
  typedef enum logic [1:0] {DIS_NONE, DIS_TRACK, DIS_NONTRACK} msv_dis_t;
  typedef enum logic [2:0] {ST_OFF, ST_WAIT80, ST_RAMP, ST_PGWAIT, ST_RUN, ST_DISCH} msv_st_t;
  typedef struct packed {
    logic suspendCtl;
    logic softOffCtl;
    logic biasLockout;
    logic above80;
    logic above95;
    logic below70;
    logic above115;
    logic senseOver4v;
    logic overTrip;
    logic offInterval;
    logic pwmOnReq;
    logic ttWithin5;
    logic ttOutside10;
    logic mainBelow0p2;
    logic modeBias;
    logic modeMain;
    logic csResistor;
    logic railSelBias;
    logic railSelGnd;
    logic pgPin;
  } msv_in_t;
endpackage

// ===== logic/msv_top.sv
// Purpose: Sequencing and protection for a memory switching rail and termination rail.
// Assumes: All fields of the comparator bundle are asynchronous to clock.
// Notes: APB slave answers with no wait states; unmapped addresses raise pslverr.
`timescale 1ns/1ps
module msv_top #(
  parameter int RampCycles = msv_pkg::RAMP_CYC,
  parameter int PgDelayCycles = msv_pkg::PG_DELAY_CYC
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire msv_pkg::msv_in_t anaIn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic highSideOn,
  output logic lowSideOn,
  output logic [3:0] refDacCode,
  output logic tripHalf,
  output logic tripFixed,
  output logic refEnable,
  output logic ttEnable,
  output logic ttHighZ,
  output logic ttLimitReduced,
  output logic trackDischarge,
  output logic dischargeSwMain,
  output logic dischargeSwTt,
  output logic dischargeRef,
  output logic feedbackInternal,
  output logic powerGoodOut,
  output logic powerGoodOe_n
);
  localparam int STEP_CYC = RampCycles / msv_pkg::DAC_STEPS;

  msv_pkg::msv_in_t syncA_q, syncB_q;
  msv_pkg::msv_st_t st_q;
  logic tick_q;
  logic [9:0] tickCnt_q;
  logic [15:0] stepCnt_q, pgCnt_q, ttSsCnt_q;
  logic [10:0] swCycCnt_q;
  logic [5:0] uvCnt_q;
  logic ovLatch_q, uvLatch_q, ocHold_q, ttGood_q, fallback_q;
  logic [1:0] ctrl_q;
  logic enReq, sleepOff, smpsActive, uvArmed, hsOn_d;
  msv_pkg::msv_dis_t disMode;

  // Three-way strap decode, shared by the discharge path and status
  function automatic msv_pkg::msv_dis_t decodeMode(input logic bias, input logic main);
    if (bias) begin
      decodeMode = msv_pkg::DIS_NONE;
    end else if (main) begin
      decodeMode = msv_pkg::DIS_TRACK;
    end else begin
      decodeMode = msv_pkg::DIS_NONTRACK;
    end
  endfunction

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers: first stage feeds only the second stage
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      syncA_q <= '0;
      syncB_q <= '0;
    end else begin
      syncA_q <= anaIn;
      syncB_q <= syncA_q;
    end
  end

  // Decoded conditions from synchronised inputs
  assign enReq = !syncB_q.biasLockout && (syncB_q.suspendCtl || syncB_q.softOffCtl);
  assign sleepOff = !syncB_q.suspendCtl && !syncB_q.softOffCtl;
  assign smpsActive = (st_q == msv_pkg::ST_WAIT80) || (st_q == msv_pkg::ST_RAMP) ||
                      (st_q == msv_pkg::ST_PGWAIT) || (st_q == msv_pkg::ST_RUN);
  assign disMode = decodeMode(syncB_q.modeBias, syncB_q.modeMain);

  ////////////////////////////////////////////////////////////////////////////
  // Switching-cycle timebase; the real part has no oscillator, so this is nominal
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tickCnt_q <= 10'h000;
      tick_q <= 1'b0;
    end else if (tickCnt_q == 10'(msv_pkg::TICK_CYC - 1)) begin
      tickCnt_q <= 10'h000;
      tick_q <= 1'b1;
    end else begin
      tickCnt_q <= tickCnt_q + 10'h001;
      tick_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main-rail sequencer; lockout overrides everything and does not latch
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= msv_pkg::ST_OFF;
    end else if (syncB_q.biasLockout) begin
      st_q <= msv_pkg::ST_OFF;
    end else if (sleepOff && st_q != msv_pkg::ST_OFF) begin
      st_q <= msv_pkg::ST_DISCH;
    end else begin
      case (st_q)
        msv_pkg::ST_OFF: begin
          if (enReq) st_q <= msv_pkg::ST_WAIT80;
        end
        msv_pkg::ST_WAIT80: begin
          if (syncB_q.above80) st_q <= msv_pkg::ST_RAMP;
        end
        msv_pkg::ST_RAMP: begin
          if (refDacCode == msv_pkg::DAC_FULL) st_q <= msv_pkg::ST_PGWAIT;
        end
        msv_pkg::ST_PGWAIT: begin
          if (pgCnt_q == 16'(PgDelayCycles - 1)) st_q <= msv_pkg::ST_RUN;
        end
        msv_pkg::ST_RUN: begin
          st_q <= msv_pkg::ST_RUN;
        end
        default: begin
          if (enReq) st_q <= msv_pkg::ST_OFF;
        end
      endcase
    end
  end

  // Reference ramp: equal steps so the full span takes the ramp time
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      refDacCode <= msv_pkg::DAC_START;
      stepCnt_q <= 16'h0000;
    end else if (st_q != msv_pkg::ST_RAMP) begin
      if (!smpsActive) refDacCode <= msv_pkg::DAC_START;
      stepCnt_q <= 16'h0000;
    end else if (stepCnt_q == 16'(STEP_CYC - 1)) begin
      stepCnt_q <= 16'h0000;
      if (refDacCode != msv_pkg::DAC_FULL) refDacCode <= refDacCode + 4'h1;
    end else begin
      stepCnt_q <= stepCnt_q + 16'h0001;
    end
  end

  // Power-good delay restarts whenever the rail drops below its good level in ST_PGWAIT
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pgCnt_q <= 16'h0000;
    end else if (st_q == msv_pkg::ST_PGWAIT && syncB_q.above95) begin
      pgCnt_q <= pgCnt_q + 16'h0001;
    end else begin
      pgCnt_q <= 16'h0000;
    end
  end

  // Open-drain power-good: enable low pulls the pin down; main rail only
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      powerGoodOut <= 1'b0;
      powerGoodOe_n <= 1'b0;
    end else begin
      powerGoodOut <= 1'b0;
      powerGoodOe_n <= (st_q == msv_pkg::ST_RUN) && syncB_q.above95;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Switching-cycle count since start, saturating so it never re-disarms
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      swCycCnt_q <= 11'h000;
    end else if (!smpsActive) begin
      swCycCnt_q <= 11'h000;
    end else if (tick_q && swCycCnt_q != 11'h7FF) begin
      swCycCnt_q <= swCycCnt_q + 11'h001;
    end
  end
  assign uvArmed = (swCycCnt_q >= 11'(msv_pkg::UV_ARM_SW)) && ctrl_q[msv_pkg::CTRL_UVP_BIT];

  // Undervoltage delay in switching cycles
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      uvCnt_q <= 6'h00;
    end else if (!(uvArmed && syncB_q.below70)) begin
      uvCnt_q <= 6'h00;
    end else if (tick_q && uvCnt_q != 6'(msv_pkg::UV_DELAY_SW)) begin
      uvCnt_q <= uvCnt_q + 6'h01;
    end
  end

  // Fault latches: a new fault wins over a clear in the same cycle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ovLatch_q <= 1'b0;
      uvLatch_q <= 1'b0;
    end else begin
      if (smpsActive && syncB_q.above115 && ctrl_q[msv_pkg::CTRL_OVP_BIT]) begin
        ovLatch_q <= 1'b1;
      end else if (syncB_q.biasLockout || sleepOff) begin
        ovLatch_q <= 1'b0;
      end
      if (uvCnt_q == 6'(msv_pkg::UV_DELAY_SW)) begin
        uvLatch_q <= 1'b1;
      end else if (syncB_q.biasLockout || sleepOff) begin
        uvLatch_q <= 1'b0;
      end
    end
  end

  // Valley hold-off: once tripped in the off interval, hold until current falls
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ocHold_q <= 1'b0;
    end else begin
      ocHold_q <= smpsActive && syncB_q.overTrip && (syncB_q.offInterval || ocHold_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gate drivers; overvoltage keeps the low side on to clamp the rail
  assign hsOn_d = smpsActive && !ovLatch_q && !uvLatch_q && !syncB_q.senseOver4v &&
                  syncB_q.pwmOnReq && !ocHold_q && !(syncB_q.offInterval && syncB_q.overTrip);
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      highSideOn <= 1'b0;
      lowSideOn <= 1'b0;
    end else begin
      highSideOn <= hsOn_d;
      if (ovLatch_q) begin
        lowSideOn <= 1'b1;
      end else if (uvLatch_q || !smpsActive) begin
        lowSideOn <= 1'b0;
      end else begin
        lowSideOn <= !hsOn_d;
      end
    end
  end

  // Current-limit steering towards the analogue comparator
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tripHalf <= 1'b1;
      tripFixed <= 1'b0;
      feedbackInternal <= 1'b0;
    end else begin
      tripHalf <= !smpsActive || st_q == msv_pkg::ST_WAIT80 || st_q == msv_pkg::ST_RAMP ||
                  ((st_q == msv_pkg::ST_PGWAIT || st_q == msv_pkg::ST_RUN) && !syncB_q.above95);
      tripFixed <= syncB_q.csResistor;
      feedbackInternal <= syncB_q.railSelBias || syncB_q.railSelGnd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sleep-state output control
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      refEnable <= 1'b0;
      ttEnable <= 1'b0;
      ttHighZ <= 1'b0;
    end else begin
      refEnable <= enReq;
      ttEnable <= enReq && syncB_q.suspendCtl && syncB_q.softOffCtl;
      ttHighZ <= enReq && !syncB_q.suspendCtl;
    end
  end

  // Termination good with hysteresis and its own soft-start counter
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ttGood_q <= 1'b0;
      ttLimitReduced <= 1'b1;
      ttSsCnt_q <= 16'h0000;
    end else begin
      if (!ttEnable || syncB_q.ttOutside10) begin
        ttGood_q <= 1'b0;
      end else if (syncB_q.ttWithin5) begin
        ttGood_q <= 1'b1;
      end
      ttLimitReduced <= !ttGood_q;
      if (!ttEnable) begin
        ttSsCnt_q <= 16'h0000;
      end else if (tick_q && !ttGood_q && ttSsCnt_q != 16'hFFFF) begin
        ttSsCnt_q <= ttSsCnt_q + 16'h0001;
      end
    end
  end

  // Discharge paths; tracking falls back once the rail is nearly empty
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      fallback_q <= 1'b0;
      trackDischarge <= 1'b0;
      dischargeSwMain <= 1'b0;
      dischargeSwTt <= 1'b0;
      dischargeRef <= 1'b0;
    end else begin
      if (st_q != msv_pkg::ST_DISCH) begin
        fallback_q <= 1'b0;
      end else if (syncB_q.mainBelow0p2) begin
        fallback_q <= 1'b1;
      end
      trackDischarge <= st_q == msv_pkg::ST_DISCH && disMode == msv_pkg::DIS_TRACK &&
                        !fallback_q && !syncB_q.mainBelow0p2;
      dischargeSwMain <= st_q == msv_pkg::ST_DISCH && (disMode == msv_pkg::DIS_NONTRACK ||
                         (disMode == msv_pkg::DIS_TRACK && (fallback_q || syncB_q.mainBelow0p2)));
      dischargeSwTt <= st_q == msv_pkg::ST_DISCH && (disMode == msv_pkg::DIS_NONTRACK ||
                       (disMode == msv_pkg::DIS_TRACK && (fallback_q || syncB_q.mainBelow0p2)));
      dischargeRef <= st_q == msv_pkg::ST_DISCH && disMode != msv_pkg::DIS_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: data prepared in setup, answered in the first access cycle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      pready <= 1'b1;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (paddr == msv_pkg::ADDR_CTRL) begin
        prdata <= {30'h00000000, ctrl_q};
      end else if (paddr == msv_pkg::ADDR_STATUS) begin
        prdata <= {16'h0000, 1'b0, st_q, refDacCode, 1'b0, disMode, ttGood_q,
                   uvLatch_q, ovLatch_q, syncB_q.pgPin, powerGoodOe_n};
      end else if (paddr == msv_pkg::ADDR_COUNT) begin
        prdata <= {ttSsCnt_q, 5'h00, swCycCnt_q};
      end else begin
        pslverr <= 1'b1;
      end
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Control word write takes effect at the completing edge only
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= msv_pkg::CTRL_RESET;
    end else if (psel && penable && pready && pwrite && paddr == msv_pkg::ADDR_CTRL) begin
      ctrl_q <= pwdata[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the sequencing and protection outputs
  a_ss_entry: assert property ((st_q == msv_pkg::ST_WAIT80) |-> (refDacCode == 4'h0)
    && tripHalf) else $error("soft start not at reduced level");
  a_ramp_step: assert property ((st_q == msv_pkg::ST_RAMP && stepCnt_q == 16'(STEP_CYC - 1)
    && refDacCode != 4'hF && !sleepOff && !syncB_q.biasLockout) |=> refDacCode == $past(refDacCode) + 4'h1)
    else $error("reference step missing");
  a_oc_restore: assert property ((st_q == msv_pkg::ST_PGWAIT && syncB_q.above95) |=>
    !tripHalf || !smpsActive) else $error("threshold not restored");
  a_pg_order: assert property ($rose(powerGoodOe_n) |-> $past(st_q) == msv_pkg::ST_RUN
    && refDacCode == 4'hF) else $error("power good early");
  a_tt_limit: assert property (ttGood_q |=> !ttLimitReduced) else $error("limit not normal");
  a_tt_hyst: assert property ((ttEnable && syncB_q.ttOutside10) |=> !ttGood_q)
    else $error("termination good kept");
  a_oc_hold: assert property ((smpsActive && syncB_q.offInterval && syncB_q.overTrip)
    |=> !highSideOn) else $error("high side on over trip");
  a_trip_fixed: assert property (syncB_q.csResistor |=> tripFixed) else $error("fixed trip off");
  a_ov_latch: assert property (ovLatch_q && !syncB_q.biasLockout && !sleepOff |=>
    ovLatch_q && lowSideOn && !highSideOn) else $error("overvoltage latch lost");
  a_sense_4v: assert property (syncB_q.senseOver4v |=> !highSideOn)
    else $error("high side on above 4 V");
  a_uv_latch: assert property ((uvCnt_q == 6'h20) |=> uvLatch_q) else $error("uv not latched");
  a_uv_armed: assert property ((swCycCnt_q < 11'h3EF) |=> !$rose(uvLatch_q) || $past(uvLatch_q)
    || $past(uvCnt_q) == 6'h20) else $error("uv armed early");
  a_lockout: assert property (syncB_q.biasLockout |=> st_q == msv_pkg::ST_OFF ##1
    (!refEnable || !syncB_q.biasLockout)) else $error("lockout ignored");
  a_no_dis: assert property ((disMode == msv_pkg::DIS_NONE) |=> !dischargeRef
    || $past(disMode) != msv_pkg::DIS_NONE) else $error("discharge in none mode");
  a_track_fb: assert property ((st_q == msv_pkg::ST_DISCH && syncB_q.mainBelow0p2) |=>
    !trackDischarge) else $error("tracking after 0.2 V");
  c_full_start: cover property (st_q == msv_pkg::ST_PGWAIT ##1 st_q == msv_pkg::ST_RUN);
  c_discharge: cover property (st_q == msv_pkg::ST_RUN ##1 st_q == msv_pkg::ST_DISCH);
  c_ov_fault: cover property ($rose(ovLatch_q));
  c_uv_fault: cover property ($rose(uvLatch_q));
endmodule

// ===== sim/msv_far_model.sv
// Purpose: Far side of the supervisor: comparators, straps, power-good pin.
// Assumes: The bench sets the wanted comparator and strap levels in want.
// Notes: The power-good pin is open drain with a pull-up on the board.
`timescale 1ns/1ps
module msv_far_model (
  input wire msv_pkg::msv_in_t want,
  input wire logic powerGoodOut,
  input wire logic powerGoodOe_n,
  output msv_pkg::msv_in_t anaIn
);
  logic pinLevel;
  // Released pin floats to the pull-up, never to a stale value
  assign pinLevel = powerGoodOe_n ? 1'b1 : powerGoodOut;
  // Sensed pin level overrides what the bench asked for
  always_comb begin
    anaIn = want;
    anaIn.pgPin = pinLevel;
  end
endmodule

// ===== sim/testbench.sv
// Purpose: Self-checking bench for the memory rail supervisor.
// Assumes: Short ramp and power-good delay parameters keep the run brief.
// Notes: Undervoltage arming needs over 600k clocks, so it is left unexercised.
`timescale 1ns/1ps
module testbench;
  localparam int Ramp = 150;
  localparam int PgDly = 40;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, highSideOn, lowSideOn, tripHalf, tripFixed;
  logic refEnable, ttEnable, ttHighZ, ttLimitReduced, trackDischarge;
  logic dischargeSwMain, dischargeSwTt, dischargeRef, feedbackInternal;
  logic powerGoodOut, powerGoodOe_n;
  logic [3:0] refDacCode;
  msv_pkg::msv_in_t want = '0;
  msv_pkg::msv_in_t anaIn;
  logic [31:0] rd;
  logic er;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  int n;
  // Mode rows: strap and select inputs beside the decoded outputs
  logic [10:0] rows [6] = '{11'h400, 11'h251, 11'h30C, 11'h0AF, 11'h00C, 11'h482};

  msv_top #(.RampCycles(Ramp), .PgDelayCycles(PgDly)) dut (.clock, .arst_n, .anaIn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .highSideOn, .lowSideOn, .refDacCode, .tripHalf, .tripFixed, .refEnable,
    .ttEnable, .ttHighZ, .ttLimitReduced, .trackDischarge, .dischargeSwMain,
    .dischargeSwTt, .dischargeRef, .feedbackInternal, .powerGoodOut, .powerGoodOe_n);
  msv_far_model far (.want, .powerGoodOut, .powerGoodOe_n, .anaIn);

  // 250 MHz clock
  always #2 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////////
  // Hang guard: whole run is about five hundred cycles
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge clock);
  endtask

  // One APB transfer; entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // Wait for the answer; only the hang guard ends a stuck transfer
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so a following call never re-drives psel in this time step
    @(posedge clock);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    step(2);
    arst_n <= 1'b1;
    step(1);
    chk(tripHalf, 1'b1);
    chk(refDacCode, msv_pkg::DAC_START);
    chk(ttLimitReduced, 1'b1);
    chk(powerGoodOe_n, 1'b0);
    apb(1'b0, msv_pkg::ADDR_CTRL, 32'h0);
    chk(rd, 32'h3);
    apb(1'b1, 8'h0C, 32'h0);
    chk(er, 1'b1);
    // Start-up: ramp waits for the 80 percent comparator
    want.suspendCtl <= 1'b1;
    want.softOffCtl <= 1'b1;
    step(8);
    chk(refDacCode, msv_pkg::DAC_START);
    want.above80 <= 1'b1;
    want.above95 <= 1'b1;
    n = 0;
    while (refDacCode !== msv_pkg::DAC_FULL && n < 400) begin
      step(1);
      n++;
    end
    chk(n >= Ramp - 15 && n <= Ramp + 10, 1'b1);
    step(3);
    chk(tripHalf, 1'b0);
    chk(powerGoodOe_n, 1'b0);
    n = 0;
    while (powerGoodOe_n !== 1'b1 && n < 200) begin
      step(1);
      n++;
    end
    chk(n >= PgDly - 10 && n <= PgDly + 10, 1'b1);
    // Termination limit hysteresis, invisible on power-good
    want.ttWithin5 <= 1'b1;
    step(5);
    chk(ttLimitReduced, 1'b0);
    apb(1'b0, msv_pkg::ADDR_STATUS, 32'h0);
    chk(rd[1:0], 2'h3);
    chk(powerGoodOut, 1'b0);
    want.ttWithin5 <= 1'b0;
    step(5);
    chk(ttLimitReduced, 1'b0);
    want.ttOutside10 <= 1'b1;
    step(5);
    chk(ttLimitReduced, 1'b1);
    chk(powerGoodOe_n, 1'b1);
    want.ttOutside10 <= 1'b0;
    want.above95 <= 1'b0;
    step(5);
    chk(tripHalf, 1'b1);
    want.above95 <= 1'b1;
    want.pwmOnReq <= 1'b1;
    want.offInterval <= 1'b1;
    want.overTrip <= 1'b1;
    step(5);
    chk(highSideOn, 1'b0);
    want.overTrip <= 1'b0;
    want.offInterval <= 1'b0;
    want.senseOver4v <= 1'b1;
    step(5);
    chk(highSideOn, 1'b0);
    want.senseOver4v <= 1'b0;
    want.suspendCtl <= 1'b0;
    step(5);
    chk(highSideOn, 1'b1);
    chk({ttHighZ, ttEnable, refEnable}, 3'h5);
    want.suspendCtl <= 1'b1;
    step(5);
    chk({ttHighZ, ttEnable}, 2'h1);
    // Overvoltage latch holds until both sleep controls drop
    want.above115 <= 1'b1;
    step(5);
    want.above115 <= 1'b0;
    step(5);
    chk({highSideOn, lowSideOn}, 2'h1);
    want.suspendCtl <= 1'b0;
    want.softOffCtl <= 1'b0;
    step(6);
    chk({refEnable, lowSideOn}, 2'h0);
    for (int i = 0; i < 6; i++) begin
      {want.modeBias, want.modeMain, want.mainBelow0p2, want.csResistor,
        want.railSelBias, want.railSelGnd} <= rows[i][10:5];
      step(6);
      chk({trackDischarge, dischargeSwMain, dischargeSwTt, tripFixed,
        feedbackInternal}, rows[i][4:0]);
    end
    // Lockout shuts everything, then a fresh start runs without latching
    want.suspendCtl <= 1'b1;
    want.softOffCtl <= 1'b1;
    step(8);
    want.biasLockout <= 1'b1;
    step(5);
    chk({refEnable, ttEnable, highSideOn}, 3'h0);
    want.biasLockout <= 1'b0;
    n = 0;
    while (refDacCode !== msv_pkg::DAC_FULL && n < 400) begin
      step(1);
      n++;
    end
    chk(refDacCode, msv_pkg::DAC_FULL);
    end_sim();
  end
endmodule
